// >>> src/tfc_pkg.sv
// Purpose: Constants for the task-file control and status register bank.
// Assumes: Byte-wide task-file port, offsets are register indices on the port.
// Notes:   All offsets, named field bit positions and byte reset values live here.
package tfc_pkg;
  // Register offsets on the task-file port.
  localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] OFS_STATUS     = 4'h7;
  localparam logic [3:0] OFS_SHADOW_CTL = 4'hE;
  localparam logic [3:0] OFS_DRIVE_ADDR = 4'hF;
  // Drive/head select fields.
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRV_BIT = 4;
  localparam logic [7:0] DH_FIXED_ONES = 8'hA0;
  localparam logic [7:0] DH_RESET      = 8'hA0;
  // Status fields.
  localparam int ST_BUSY = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DWF  = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORRECTED_ERROR_FLAG = 2;
  localparam int ST_ERR  = 0;
  // Device control fields.
  localparam int DC_SRST = 2;
  localparam int DC_IDIS = 1;
  // Error register fields.
  localparam int ER_BBK  = 7;
  localparam int ER_UNC  = 6;
  localparam int ER_SECTOR_NOT_FOUND_FLAG = 4;
  localparam int ER_ABRT = 2;
  localparam int ER_GENERAL_ERROR_FLAG = 0;
  localparam logic [7:0] ER_USED_MASK = 8'hD5;
  // Diagnostic code loaded by a soft reset; value is arbitrary.
  localparam logic [7:0] DIAG_CODE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// >>> src/tfc_regs.sv
// Purpose: Drive/head select, status, shadow status, device control and
//          drive address readback registers of an ATA-style task file.
// Assumes: Host strobes arrive already synchronous to ref_clk; the command
//          engine reports its flags as same-clock pulses and levels.
// Notes:   Read data is registered, so it appears one cycle after the strobe.
//
// Overview of operation
// RULE_01: Drive/head register at 6h, bits 7,5 one.
// RULE_02: Bit 6 picks CHS or logical block.
// RULE_03: Block address built from four registers.
// RULE_04: Bit 4 selects drive 0 or 1.
// RULE_05: Low nibble is head or address 27..24.
// RULE_06: Status readable at 7h and shadow Eh.
// RULE_07: Primary status read clears pending interrupt.
// RULE_08: Busy locks host out of command access.
// RULE_09: Ready clear from power-up until able.
// RULE_10: Status bit 5 flags write fault.
// RULE_11: Data request set on need, cleared next command.
// RULE_12: Bit 2 flags corrected error, read continues.
// RULE_13: Status bit 1 always reads zero.
// RULE_14: Error bit set on failure, cleared next command.
// RULE_15: Device control writable at Eh even busy.
// RULE_16: Soft reset bit clears status, loads diagnostic.
// RULE_17: Control bit 1 disables interrupt, zero at reset.
// RULE_18: Host writes zero to control bits 7..3.
// RULE_19: Address reg bit 6 low while writing.
// RULE_20: Address bits 5..2 invert head select.
// RULE_21: Bits 1,0 low for selected drive.
// RULE_22: Host prefers shadow status for word access.
// RULE_23: Error register layout, unused bits zero.
// RULE_24: Error and request flags change only on events.
`timescale 1ns/1ps
`default_nettype none
module tfc_regs #(
  parameter int ADDR_W = 4
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Host task-file port.
  input  wire logic              host_rd,
  input  wire logic              host_wr,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [7:0]        host_wdata,
  output var  logic [7:0]        host_rdata,
  // Address bytes from the rest of the task file.
  input  wire logic [7:0]        sector_number,
  input  wire logic [7:0]        cylinder_low,
  input  wire logic [7:0]        cylinder_high,
  // Command engine events and levels.
  input  wire logic              cmd_issue,
  input  wire logic              cmd_done,
  input  wire logic              cmd_done_err,
  input  wire logic [7:0]        cmd_err_bits,
  input  wire logic              data_req_set,
  input  wire logic              engine_busy,
  input  wire logic              engine_ready,
  input  wire logic              write_fault,
  input  wire logic              corrected_error,
  input  wire logic              write_active,
  input  wire logic              irq_event,
  // Outputs toward the command engine and the host.
  output var  logic [27:0]       block_address,
  output var  logic              lba_mode,
  output var  logic              drive_number_bit,
  output var  logic [3:0]        head_number,
  output var  logic              soft_reset_active,
  output var  logic              host_locked,
  output var  logic [7:0]        error_reg,
  output var  logic              interrupt_request_n,
  output var  logic              config_int_flag
);

  logic [7:0] drive_head_ff;
  logic [7:0] status_ff;
  logic [7:0] error_ff;
  logic       srst_ff;
  logic       irq_dis_ff;
  logic       irq_pend_ff;
  logic [7:0] nxt_status;
  logic [7:0] addr_readback;

  // Decodes a host access to one register offset.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a[3:0] == ofs);
  endfunction

  wire logic wr_dh   = host_wr & hit(host_addr, tfc_pkg::OFS_DRIVE_HEAD) & ~status_ff[tfc_pkg::ST_BUSY];
  wire logic wr_ctl  = host_wr & hit(host_addr, tfc_pkg::OFS_SHADOW_CTL);
  wire logic rd_stat = host_rd & hit(host_addr, tfc_pkg::OFS_STATUS);

  // Drive/head select; host writes are refused while busy so the engine sees stable values.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_head_ff <= tfc_pkg::DH_RESET;
    end else if (srst_ff) begin
      drive_head_ff <= tfc_pkg::DH_RESET;
    end else if (wr_dh) begin // RULE_08
      drive_head_ff <= host_wdata | tfc_pkg::DH_FIXED_ONES; // RULE_01
    end
  end

  // Device control accepted at any time, busy or not; reserved bits are dropped.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      srst_ff    <= 1'b0;
      irq_dis_ff <= 1'b0; // RULE_17
    end else if (wr_ctl) begin // RULE_15
      srst_ff    <= host_wdata[tfc_pkg::DC_SRST]; // RULE_16
      irq_dis_ff <= host_wdata[tfc_pkg::DC_IDIS]; // RULE_17
    end
  end

  // Next status: sticky flags are set by events and cleared only by a new command or a soft reset.
  always_comb begin
    nxt_status = status_ff;
    nxt_status[tfc_pkg::ST_BUSY] = engine_busy;
    nxt_status[tfc_pkg::ST_RDY]  = engine_ready & ~engine_busy; // RULE_09
    nxt_status[tfc_pkg::ST_DSC]  = engine_ready & ~engine_busy;
    nxt_status[1] = 1'b0; // RULE_13
    if (cmd_issue) begin
      nxt_status[tfc_pkg::ST_DRQ]  = 1'b0; // RULE_11
      nxt_status[tfc_pkg::ST_ERR]  = 1'b0; // RULE_14
      nxt_status[tfc_pkg::ST_DWF]  = 1'b0;
      nxt_status[tfc_pkg::ST_CORRECTED_ERROR_FLAG] = 1'b0;
    end
    // Sets come last so an event in the clearing cycle is not lost.
    if (data_req_set) nxt_status[tfc_pkg::ST_DRQ] = 1'b1; // RULE_11 RULE_24
    if (cmd_done_err) nxt_status[tfc_pkg::ST_ERR] = 1'b1; // RULE_14 RULE_24
    if (write_fault) nxt_status[tfc_pkg::ST_DWF] = 1'b1; // RULE_10
    if (corrected_error) nxt_status[tfc_pkg::ST_CORRECTED_ERROR_FLAG] = 1'b1; // RULE_12
  end

  // Status register; soft reset holds it cleared for as long as the bit stays set.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_ff <= tfc_pkg::ZERO_BYTE; // RULE_09
    end else if (srst_ff) begin
      status_ff <= tfc_pkg::ZERO_BYTE; // RULE_16
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Error register; failures load cause bits, reserved positions forced to zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      error_ff <= tfc_pkg::ZERO_BYTE;
    end else if (srst_ff) begin
      error_ff <= tfc_pkg::DIAG_CODE; // RULE_16
    end else if (cmd_done_err) begin
      error_ff <= cmd_err_bits & tfc_pkg::ER_USED_MASK; // RULE_23 RULE_14
    end else if (cmd_issue) begin
      error_ff <= tfc_pkg::ZERO_BYTE;
    end
  end

  // Pending interrupt; an event in the same cycle as a status read wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_pend_ff <= 1'b0;
    end else if (srst_ff) begin
      irq_pend_ff <= 1'b0;
    end else if (irq_event | cmd_done) begin
      irq_pend_ff <= 1'b1;
    end else if (rd_stat) begin
      irq_pend_ff <= 1'b0; // RULE_07
    end
  end

  // Drive address readback: inverted head bits and active-low drive selects.
  always_comb begin
    addr_readback = tfc_pkg::ZERO_BYTE; // Bit 7 is don't care and reads zero.
    addr_readback[6] = ~write_active; // RULE_19
    addr_readback[5:2] = ~drive_head_ff[3:0]; // RULE_20
    addr_readback[1] = ~drive_head_ff[tfc_pkg::DH_DRV_BIT]; // RULE_21
    addr_readback[0] = drive_head_ff[tfc_pkg::DH_DRV_BIT]; // RULE_21
  end

  // Registered read mux; unmapped offsets read zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_rdata <= tfc_pkg::ZERO_BYTE;
    end else if (host_rd) begin
      case (host_addr[3:0])
        tfc_pkg::OFS_DRIVE_HEAD: host_rdata <= drive_head_ff;
        tfc_pkg::OFS_STATUS:     host_rdata <= status_ff; // RULE_06
        tfc_pkg::OFS_SHADOW_CTL: host_rdata <= status_ff; // RULE_06 RULE_22
        tfc_pkg::OFS_DRIVE_ADDR: host_rdata <= addr_readback;
        default:                 host_rdata <= tfc_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Outputs toward the engine and the host, all registered.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      block_address       <= '0;
      lba_mode            <= 1'b0;
      drive_number_bit    <= 1'b0;
      head_number         <= 4'h0;
      soft_reset_active   <= 1'b0;
      host_locked         <= 1'b0;
      error_reg           <= tfc_pkg::ZERO_BYTE;
      interrupt_request_n <= 1'b1;
      config_int_flag     <= 1'b0;
    end else begin
      block_address       <= {drive_head_ff[3:0], cylinder_high, cylinder_low,
                              sector_number}; // RULE_03 RULE_05
      lba_mode            <= drive_head_ff[tfc_pkg::DH_LBA_BIT]; // RULE_02
      drive_number_bit    <= drive_head_ff[tfc_pkg::DH_DRV_BIT]; // RULE_04
      head_number         <= drive_head_ff[3:0]; // RULE_05
      soft_reset_active   <= srst_ff; // RULE_16
      host_locked         <= status_ff[tfc_pkg::ST_BUSY]; // RULE_08
      error_reg           <= error_ff; // RULE_23
      interrupt_request_n <= ~(irq_pend_ff & ~irq_dis_ff); // RULE_17
      config_int_flag     <= irq_dis_ff; // RULE_17
    end
  end

  // Fixed-one bits of drive/head never drop.
  dh_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
    (drive_head_ff & tfc_pkg::DH_FIXED_ONES) == tfc_pkg::DH_FIXED_ONES) // RULE_01
    else $error("drive head fixed bits lost");
  // A drive/head write while idle lands next cycle.
  dh_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_dh && !srst_ff |=> drive_head_ff == ($past(host_wdata) | 8'hA0)) // RULE_05
    else $error("drive head write not taken");
  // Status read clears pending interrupt absent a new event.
  irq_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_stat && !irq_event && !cmd_done |=> !irq_pend_ff) // RULE_07
    else $error("status read did not clear interrupt");
  // Disabled interrupts keep the pin high two cycles later.
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    irq_dis_ff ##1 irq_dis_ff |=> interrupt_request_n) // RULE_17
    else $error("interrupt leaked while disabled");
  // Soft reset clears status and loads diagnostic code.
  srst_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    srst_ff |=> status_ff == 8'h00 && error_ff == 8'h01) // RULE_16
    else $error("soft reset did not clear status");
  // Status bit 1 never set.
  idx_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    !status_ff[1]) // RULE_13
    else $error("status bit 1 set");
  // New command clears request and error unless set same cycle.
  cmd_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_issue && !data_req_set && !cmd_done_err && !srst_ff |=>
    !status_ff[3] && !status_ff[0]) // RULE_11
    else $error("command did not clear flags");
  // Error flag stable without an event.
  err_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cmd_issue && !cmd_done_err && !srst_ff |=> $stable(status_ff[0])) // RULE_24
    else $error("error flag changed without cause");
  // Readback follows inverted head bits.
  addr_inv_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_rd && host_addr[3:0] == 4'hF |=> host_rdata[5:2] == ~$past(drive_head_ff[3:0])) // RULE_20
    else $error("readback head bits wrong");
  // Control write accepted even while busy.
  ctl_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctl |=> srst_ff == $past(host_wdata[2])) // RULE_15
    else $error("control write refused");

  // Each sticky status flag is raised by its own event unless soft reset holds it.
  drq_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    data_req_set && !srst_ff |=> status_ff[tfc_pkg::ST_DRQ]) // RULE_11
    else $error("data request flag not set");
  err_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_done_err && !srst_ff |=> status_ff[tfc_pkg::ST_ERR]) // RULE_14
    else $error("error flag not set");
  dwf_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    write_fault && !srst_ff |=> status_ff[tfc_pkg::ST_DWF]) // RULE_10
    else $error("write fault flag not set");
  corrected_error_flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    corrected_error && !srst_ff |=> status_ff[tfc_pkg::ST_CORRECTED_ERROR_FLAG]) // RULE_12
    else $error("corrected error flag not set");

  // Ready never shows together with busy, so a host cannot see a false ready.
  rdy_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
    status_ff[tfc_pkg::ST_BUSY] |-> !status_ff[tfc_pkg::ST_RDY]) // RULE_09
    else $error("ready shown while busy");
  // A drive/head write while busy leaves the register untouched.
  dh_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_wr && hit(host_addr, tfc_pkg::OFS_DRIVE_HEAD) && status_ff[tfc_pkg::ST_BUSY] &&
    !srst_ff |=> $stable(drive_head_ff)) // RULE_08
    else $error("drive head written while busy");

  // Registered outputs follow the drive/head fields one cycle later.
  lba_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> lba_mode == $past(drive_head_ff[tfc_pkg::DH_LBA_BIT])) // RULE_02
    else $error("addressing mode wrong");
  blk_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> block_address[27:24] == $past(drive_head_ff[3:0])) // RULE_03
    else $error("block address high nibble wrong");

  // Readback: exactly one drive select low, write bit tracks the engine.
  drv_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    addr_readback[1] != addr_readback[0]) // RULE_21
    else $error("drive select readback wrong");
  wtg_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    addr_readback[6] == !write_active) // RULE_19
    else $error("write in progress readback wrong");

  // Reserved error bits stay zero whatever the engine reports.
  err_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    (error_ff & ~tfc_pkg::ER_USED_MASK) == tfc_pkg::ZERO_BYTE) // RULE_23
    else $error("reserved error bit set");
  // A shadow status read never clears a pending interrupt.
  shadow_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    irq_pend_ff && host_rd && hit(host_addr, tfc_pkg::OFS_SHADOW_CTL) && !srst_ff
    |=> irq_pend_ff) // RULE_07
    else $error("shadow read cleared interrupt");

endmodule
`default_nettype wire

// >>> dv/tfc_host_model.sv
// Purpose: Host side of the task-file port, one byte access at a time.
// Assumes: Strobes change 1 ns after a rising edge and last one cycle.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module tfc_host_model (
  // Clock.
  input  wire logic       ref_clk,
  // Task-file port.
  output var  logic       host_rd,
  output var  logic       host_wr,
  output var  logic [3:0] host_addr,
  output var  logic [7:0] host_wdata,
  input  wire logic [7:0] host_rdata
);
  // Nothing is requested until the first access.
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 4'h0;
    host_wdata = 8'h00;
  end

  // One byte-wide cycle; read data settles one edge after the strobe and is sampled two edges after it drops.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    host_rd <= !w;
    host_wr <= w;
    host_addr <= a;
    host_wdata <= d;
    @(posedge ref_clk);
    #1;
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
    repeat (2) @(posedge ref_clk);
    #1;
    q = host_rdata;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_ata_task_file_control_status.sv
// Purpose: Self-checking bench for the task-file control and status bank.
// Assumes: Events are one-cycle pulses; the host model does the bus cycles.
// Notes:   Drive/head values are random from a fixed seed plus corner cases.
`timescale 1ns/1ps
`default_nettype none
module tb_ata_task_file_control_status;
  logic ref_clk, rst, host_rd, host_wr, engine_busy, engine_ready, write_active;
  logic [3:0] host_addr, head_number;
  logic [7:0] host_wdata, host_rdata, sector_number, cylinder_low, cylinder_high;
  logic [7:0] cmd_err_bits, error_reg, q, v;
  logic cmd_issue, cmd_done, cmd_done_err, data_req_set, write_fault, corrected_error;
  logic irq_event;
  logic [27:0] block_address;
  logic lba_mode, drive_number_bit, soft_reset_active, host_locked;
  logic interrupt_request_n, config_int_flag;
  int n_fail, samples_checked, cyc, seed;

  // Host model and design under test.
  tfc_host_model h (.ref_clk, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata);
  tfc_regs dut (
    .ref_clk(ref_clk), .rst(rst), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .sector_number(sector_number), .cylinder_low(cylinder_low),
    .cylinder_high(cylinder_high), .cmd_issue(cmd_issue), .cmd_done(cmd_done),
    .cmd_done_err(cmd_done_err), .cmd_err_bits(cmd_err_bits),
    .data_req_set(data_req_set), .engine_busy(engine_busy), .engine_ready(engine_ready),
    .write_fault(write_fault), .corrected_error(corrected_error),
    .write_active(write_active), .irq_event(irq_event), .block_address(block_address),
    .lba_mode(lba_mode), .drive_number_bit(drive_number_bit), .head_number(head_number),
    .soft_reset_active(soft_reset_active), .host_locked(host_locked),
    .error_reg(error_reg), .interrupt_request_n(interrupt_request_n),
    .config_int_flag(config_int_flag)
  );

  // 10 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Cycle ceiling; a hang counts as a mismatch and ends the run.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  // Compares one value; every call counts as a sample.
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single place where the run ends.
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle engine pulses: issue, done, done_err, drq, dwf, corrected_error_flag, irq.
  task automatic ev(input logic [6:0] e);
    @(posedge ref_clk);
    #1;
    {cmd_issue, cmd_done, cmd_done_err, data_req_set, write_fault, corrected_error,
     irq_event} = e;
    @(posedge ref_clk);
    #1;
    {cmd_issue, cmd_done, cmd_done_err, data_req_set, write_fault, corrected_error,
     irq_event} = 7'h00;
  endtask

  // Expected drive address readback; bit 7 reads zero, selected drive reads low.
  function automatic logic [7:0] exp_readback(input logic [7:0] dh, input logic wa);
    exp_readback = {1'b0, ~wa, ~dh[3:0], ~dh[4], dh[4]};
  endfunction

  initial begin
    rst = 1'b1;
    {cmd_issue, cmd_done, cmd_done_err, data_req_set, write_fault, corrected_error,
     irq_event} = 7'h00;
    cmd_err_bits = 8'h00;
    engine_busy = 1'b0;
    engine_ready = 1'b0;
    write_active = 1'b0;
    sector_number = 8'h00;
    cylinder_low = 8'h00;
    cylinder_high = 8'h00;
    seed = $urandom(32'hba4e9a5b);
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check(interrupt_request_n, 1'b1);
    h.acc(1'b0, tfc_pkg::OFS_STATUS, 8'h00, q);
    check(q, 8'h00);
    engine_ready = 1'b1;
    h.acc(1'b0, tfc_pkg::OFS_SHADOW_CTL, 8'h00, q);
    check(q, 8'h50);
    // Random drive/head values with all-zero and all-one corners first.
    for (int i = 0; i < 20; i++) begin
      v = 8'($urandom);
      if (i == 0) v = 8'h00;
      if (i == 1) v = 8'hFF;
      sector_number = 8'($urandom);
      cylinder_low = 8'($urandom);
      cylinder_high = 8'($urandom);
      write_active = 1'($urandom);
      h.acc(1'b1, tfc_pkg::OFS_DRIVE_HEAD, v, q);
      h.acc(1'b0, tfc_pkg::OFS_DRIVE_HEAD, 8'h00, q);
      check(q, v | 8'hA0);
      h.acc(1'b0, tfc_pkg::OFS_DRIVE_ADDR, 8'h00, q);
      check(q, exp_readback(v, write_active));
      check(q[1:0], v[4] ? 2'b01 : 2'b10);
      check(q[6], !write_active);
      check(lba_mode, v[6]);
      check(drive_number_bit, v[4]);
      check(head_number, v[3:0]);
      check(block_address, {v[3:0], cylinder_high, cylinder_low, sector_number});
    end
    // Busy refuses drive/head writes but not device control.
    engine_busy = 1'b1;
    h.acc(1'b1, tfc_pkg::OFS_DRIVE_HEAD, ~v, q);
    h.acc(1'b0, tfc_pkg::OFS_DRIVE_HEAD, 8'h00, q);
    check(q, v | 8'hA0);
    check(host_locked, 1'b1);
    h.acc(1'b0, tfc_pkg::OFS_STATUS, 8'h00, q);
    check(q[7:6], 2'b10);
    h.acc(1'b1, tfc_pkg::OFS_SHADOW_CTL, 8'h04, q);
    check(soft_reset_active, 1'b1);
    check(error_reg, tfc_pkg::DIAG_CODE);
    h.acc(1'b0, tfc_pkg::OFS_STATUS, 8'h00, q);
    check(q, 8'h00);
    h.acc(1'b1, tfc_pkg::OFS_SHADOW_CTL, 8'h00, q);
    engine_busy = 1'b0;
    check(soft_reset_active, 1'b0);
    // Sticky flags set by events, cleared by the next command.
    v = 8'($urandom);
    cmd_err_bits = v;
    ev(7'b0011110);
    h.acc(1'b0, tfc_pkg::OFS_SHADOW_CTL, 8'h00, q);
    check(q[5], 1'b1);
    check(q[3], 1'b1);
    check(q[2], 1'b1);
    check(q[1], 1'b0);
    check(q[0], 1'b1);
    check(error_reg, v & 8'hD5);
    ev(7'b1000000);
    h.acc(1'b0, tfc_pkg::OFS_SHADOW_CTL, 8'h00, q);
    check(q, 8'h50);
    check(error_reg, 8'h00);
    // Interrupt: shadow read keeps it, status read clears it, bit 1 masks it.
    ev(7'b0100000);
    repeat (2) @(posedge ref_clk);
    #1;
    check(interrupt_request_n, 1'b0);
    h.acc(1'b0, tfc_pkg::OFS_SHADOW_CTL, 8'h00, q);
    check(interrupt_request_n, 1'b0);
    h.acc(1'b0, tfc_pkg::OFS_STATUS, 8'h00, q);
    check(interrupt_request_n, 1'b1);
    h.acc(1'b1, tfc_pkg::OFS_SHADOW_CTL, 8'h02, q);
    check(config_int_flag, 1'b1);
    ev(7'b0000001);
    repeat (2) @(posedge ref_clk);
    #1;
    check(interrupt_request_n, 1'b1);
    h.acc(1'b1, tfc_pkg::OFS_SHADOW_CTL, 8'h00, q);
    check(interrupt_request_n, 1'b0);
    // Reset in mid-run returns every register to its idle value.
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check(interrupt_request_n, 1'b1);
    check(error_reg, 8'h00);
    h.acc(1'b0, tfc_pkg::OFS_DRIVE_HEAD, 8'h00, q);
    check(q, 8'hA0);
    print_verdict();
  end
endmodule
`default_nettype wire
